// ==== mss_switch_top.v ====
// Contract
// - Output follows field past active threshold
// - Hysteresis between on and off thresholds
// - Faults or overtemperature force high impedance
// - High impedance is the safe state
// - Monitor regulator, bias, reference, plate
// - Self-test accepted once per power-on
// - Start only after low then rise
// - First window: simulated field, low impedance
// - Second window: opposite field, high impedance
// - Always return to normal after test
`include "mss_map.vh"
`timescale 1ns/1ns
`default_nettype none
module mss_switch_top #(
   parameter [15:0] EN_CYCLES   = `MSS_EN_CYCLES,
   parameter [15:0] WIN1_CYCLES = `MSS_WIN1_CYCLES,
   parameter [15:0] WIN2_CYCLES = `MSS_WIN2_CYCLES
) (
   input  wire clk_i,
   input  wire srst_i,
   input  wire ce_i,
   input  wire cmp_above_on_i,
   input  wire cmp_below_off_i,
   input  wire ovt_i,
   input  wire reg_ov_i,
   input  wire bias_err_i,
   input  wire vref_err_i,
   input  wire plate_err_i,
   input  wire out_below_low_output_level_i,
   input  wire out_above_selftest_trigger_level_i,
   output wire out_o,
   output wire out_oe_n_o,
   output wire fault_o,
   output wire selftest_active_o,
   output wire selftest_done_o
);
   ////////////////////////////////////////////////////////////////////////////////////
   // Input synchronisation
   wire [`MSS_FLT_W-1:0] flt_raw;
   wire [`MSS_FLT_W-1:0] flt_s;
   wire                  pin_low_s;
   wire                  pin_trig_s;
   wire                  above_s;
   wire                  below_s;
   assign flt_raw[`MSS_FLT_OVT]   = ovt_i;
   assign flt_raw[`MSS_FLT_REGOV] = reg_ov_i;
   assign flt_raw[`MSS_FLT_BIAS]  = bias_err_i;
   assign flt_raw[`MSS_FLT_VREF]  = vref_err_i;
   assign flt_raw[`MSS_FLT_PLATE] = plate_err_i;
   mss_sync #(.W(`MSS_FLT_W + 4)) u_sync (
      .clk_i  (clk_i),
      .srst_i (srst_i),
      .ce_i   (ce_i),
      .d_i    ({flt_raw, out_below_low_output_level_i,
                out_above_selftest_trigger_level_i, cmp_above_on_i, cmp_below_off_i}),
      .q_o    ({flt_s, pin_low_s, pin_trig_s, above_s, below_s})
   );
   ////////////////////////////////////////////////////////////////////////////////////
   // Switching decision with hysteresis
   reg  [2:0]  st_q;
   reg  [2:0]  st_d;
   reg  [15:0] cnt_q;
   reg  [15:0] cnt_d;
   reg         used_q;
   reg         used_d;
   wire        in_test;
   wire        sim_on;
   wire        sim_off;
   wire        sw_state;
   assign in_test = (st_q == `MSS_ST_WIN1) || (st_q == `MSS_ST_WIN2);
   assign sim_on  = (st_q == `MSS_ST_WIN1);
   assign sim_off = (st_q == `MSS_ST_WIN2);
   mss_hyst u_hyst (
      .clk_i       (clk_i),
      .srst_i      (srst_i),
      .ce_i        (ce_i),
      .above_on_i  (in_test ? sim_on : above_s),
      .below_off_i (in_test ? sim_off : below_s),
      .state_o     (sw_state)
   );
   ////////////////////////////////////////////////////////////////////////////////////
   // Power-on self-test sequencer
   always @* begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      used_d = used_q;
      case (st_q)
         `MSS_ST_WAIT_LOW: begin
            if (pin_trig_s && !pin_low_s) begin
               st_d   = `MSS_ST_DONE;
               used_d = 1'b1;
            end else if (pin_low_s) begin
               if (cnt_q >= EN_CYCLES - 16'h0001) begin
                  st_d  = `MSS_ST_ARMED;
                  cnt_d = 16'h0000;
               end else begin
                  cnt_d = cnt_q + 16'h0001;
               end
            end else begin
               cnt_d = 16'h0000;
            end
         end
         `MSS_ST_ARMED: begin
            if (pin_trig_s && !used_q) begin
               st_d   = `MSS_ST_WIN1;
               used_d = 1'b1;
               cnt_d  = 16'h0000;
            end
         end
         `MSS_ST_WIN1: begin
            if (cnt_q >= WIN1_CYCLES - 16'h0001) begin
               st_d  = `MSS_ST_WIN2;
               cnt_d = 16'h0000;
            end else begin
               cnt_d = cnt_q + 16'h0001;
            end
         end
         `MSS_ST_WIN2: begin
            if (cnt_q >= WIN2_CYCLES - 16'h0001) begin
               st_d  = `MSS_ST_DONE;
               cnt_d = 16'h0000;
            end else begin
               cnt_d = cnt_q + 16'h0001;
            end
         end
         `MSS_ST_DONE: begin
            st_d = `MSS_ST_DONE;
         end
         default: begin
            st_d  = `MSS_ST_DONE;
            cnt_d = 16'h0000;
         end
      endcase
   end
   always @(posedge clk_i) begin
      if (srst_i) begin
         st_q   <= `MSS_ST_WAIT_LOW;
         cnt_q  <= 16'h0000;
         used_q <= 1'b0;
      end else if (ce_i) begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         used_q <= used_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////
   // Output stage with safe-state override
   reg out_lowz_q;
   reg fault_q;
   wire fault_any;
   assign fault_any = |flt_s;
   always @(posedge clk_i) begin
      if (srst_i) begin
         out_lowz_q <= `MSS_OUT_HIZ;
         fault_q    <= 1'b0;
      end else if (ce_i) begin
         fault_q <= fault_any;
         if (fault_any) begin
            out_lowz_q <= `MSS_OUT_HIZ;
         end else if (st_q == `MSS_ST_WIN1) begin
            out_lowz_q <= `MSS_OUT_LOWZ;
         end else if (st_q == `MSS_ST_WIN2) begin
            out_lowz_q <= `MSS_OUT_HIZ;
         end else begin
            out_lowz_q <= sw_state;
         end
      end
   end
   assign out_o             = 1'b0;
   assign out_oe_n_o        = ~out_lowz_q;
   assign fault_o           = fault_q;
   assign selftest_active_o = in_test;
   assign selftest_done_o   = (st_q == `MSS_ST_DONE);
endmodule // mss_switch_top
`default_nettype wire

// ==== mss_map.vh ====
`ifndef MSS_MAP_VH
`define MSS_MAP_VH
// Output stage codes
`define MSS_OUT_HIZ      1'b0
`define MSS_OUT_LOWZ     1'b1
// Self-test sequencer states
`define MSS_ST_WAIT_LOW  3'h0
`define MSS_ST_ARMED     3'h1
`define MSS_ST_WIN1      3'h2
`define MSS_ST_WIN2      3'h3
`define MSS_ST_DONE      3'h4
// Default timing counts in sampling clock cycles
`define MSS_EN_CYCLES    16'h00c8
`define MSS_WIN1_CYCLES  16'h0064
`define MSS_WIN2_CYCLES  16'h0064
// Fault flag positions
`define MSS_FLT_OVT      0
`define MSS_FLT_REGOV    1
`define MSS_FLT_BIAS     2
`define MSS_FLT_VREF     3
`define MSS_FLT_PLATE    4
`define MSS_FLT_W        5
`endif

// ==== mss_sync.v ====
`timescale 1ns/1ns
`default_nettype none
module mss_sync #(
   parameter W = 1
) (
   input  wire         clk_i,
   input  wire         srst_i,
   input  wire         ce_i,
   input  wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   always @(posedge clk_i) begin
      if (srst_i) begin
         s1_q <= {W{1'b0}};
         s2_q <= {W{1'b0}};
      end else if (ce_i) begin
         s1_q <= d_i;
         s2_q <= s1_q;
      end
   end
   assign q_o = s2_q;
endmodule // mss_sync
`default_nettype wire

// ==== mss_hyst.v ====
`timescale 1ns/1ns
`default_nettype none
module mss_hyst (
   input  wire clk_i,
   input  wire srst_i,
   input  wire ce_i,
   input  wire above_on_i,
   input  wire below_off_i,
   output wire state_o
);
   reg state_q;
   // Latch between thresholds: holds state in the band
   always @(posedge clk_i) begin
      if (srst_i) begin
         state_q <= 1'b0;
      end else if (ce_i) begin
         if (!state_q && above_on_i) begin
            state_q <= 1'b1;
         end else if (state_q && below_off_i) begin
            state_q <= 1'b0;
         end
      end
   end
   assign state_o = state_q;
endmodule // mss_hyst
`default_nettype wire

// ==== mss_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module mss_chk #(
   parameter [15:0] WIN1_CYCLES = 16'h0064
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic cmp_above_on_i,
   input wire logic cmp_below_off_i,
   input wire logic ovt_i,
   input wire logic reg_ov_i,
   input wire logic bias_err_i,
   input wire logic vref_err_i,
   input wire logic plate_err_i,
   input wire logic out_above_selftest_trigger_level_i,
   input wire logic out_oe_n_o,
   input wire logic fault_o,
   input wire logic selftest_active_o,
   input wire logic selftest_done_o
);
   logic [15:0] act_q;
   wire         any = ovt_i | reg_ov_i | bias_err_i | vref_err_i | plate_err_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i || !ce_i);
   // Cycles spent in the test windows
   always @(posedge clk_i) begin
      if (srst_i || !selftest_active_o) begin
         act_q <= 16'h0000;
      end else if (ce_i) begin
         act_q <= act_q + 16'h0001;
      end
   end
   a_fault_hiz: assert property (any [*5] |-> out_oe_n_o && fault_o)
      else $error("fault not released");
   a_fault_quiet: assert property (!any [*5] |-> !fault_o)
      else $error("spurious fault");
   a_reset_safe: assert property ($past(srst_i) |-> out_oe_n_o && !selftest_done_o)
      else $error("reset state wrong");
   a_start_order: assert property ($rose(selftest_active_o) |->
      $past(out_above_selftest_trigger_level_i, 2))
      else $error("test without trigger");
   a_win1_lowz: assert property (selftest_active_o && !fault_o && act_q > 16'h0000
      && act_q < WIN1_CYCLES |-> !out_oe_n_o)
      else $error("window one not low");
   a_win2_hiz: assert property (selftest_active_o && act_q > WIN1_CYCLES |-> out_oe_n_o)
      else $error("window two not released");
   a_once_only: assert property (selftest_done_o |=> selftest_done_o && !selftest_active_o)
      else $error("test restarted");
   a_on_lowz: assert property ((selftest_done_o && !any && cmp_above_on_i) [*6]
      |-> !out_oe_n_o)
      else $error("no switch on");
   a_hold_state: assert property ((selftest_done_o && !any && !cmp_above_on_i
      && !cmp_below_off_i) [*6] |-> $stable(out_oe_n_o))
      else $error("output moved in band");
endmodule // mss_chk
bind mss_switch_top mss_chk #(.WIN1_CYCLES(WIN1_CYCLES)) u_chk (.*);
`default_nettype wire

// ==== mss_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module mss_host (
   input  wire logic host_low_i,
   input  wire logic dev_oe_n_i,
   output logic      below_o,
   output logic      above_o
);
   // Pull-up wins unless either side pulls low
   assign below_o = host_low_i | ~dev_oe_n_i;
   assign above_o = ~below_o;
endmodule // mss_host
`default_nettype wire

// ==== tb_magnetic_switch_selftest_safestate.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin \
   #1; \
   check_count++; \
   if ((g) !== (e)) begin \
      error_cnt++; \
      $display("wrong value %s exp %b got %b", n, e, g); \
   end \
end
module tb_magnetic_switch_selftest_safestate;
   logic       clk_i = 1'b0;
   logic       srst_i = 1'b1;
   logic       above = 1'b0;
   logic       below = 1'b0;
   logic       host_low = 1'b1;
   logic       ce = 1'b1;
   logic [4:0] flt = 5'h00;
   wire        oe_n, flt_o, act, done, lo, hi, dout;
   int         error_cnt = 0;
   int         check_count = 0;
   always #5 clk_i = ~clk_i;
   mss_host u_host (.host_low_i(host_low), .dev_oe_n_i(oe_n), .below_o(lo), .above_o(hi));
   mss_switch_top #(.EN_CYCLES(16'h0004), .WIN1_CYCLES(16'h0006), .WIN2_CYCLES(16'h0006))
      u_dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce), .cmp_above_on_i(above),
      .cmp_below_off_i(below), .ovt_i(flt[0]), .reg_ov_i(flt[1]), .bias_err_i(flt[2]),
      .vref_err_i(flt[3]), .plate_err_i(flt[4]), .out_below_low_output_level_i(lo),
      .out_above_selftest_trigger_level_i(hi), .out_o(dout), .out_oe_n_o(oe_n),
      .fault_o(flt_o), .selftest_active_o(act), .selftest_done_o(done));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic wait_on(input bit d);
      int i;
      for (i = 0; i < 60 && (d ? done : act) !== 1'b1; i++) begin
         cyc(1);
         #1;
      end
      if (i == 60) begin
         error_cnt++;
         report_and_stop;
      end
   endtask
   task automatic t_selftest;
      cyc(10);
      host_low <= 1'b0;
      wait_on(1'b0);
      cyc(2);
      `CHK("oe win1", 1'b0, oe_n)
      cyc(6);
      `CHK("oe win2", 1'b1, oe_n)
      wait_on(1'b1);
      `CHK("active", 1'b0, act)
      cyc(1);
      host_low <= 1'b1;
      cyc(10);
      host_low <= 1'b0;
      cyc(5);
      `CHK("retrigger", 1'b0, act)
      `CHK("retrigger oe", 1'b1, oe_n)
      `CHK("still done", 1'b1, done)
      cyc(15);
      `CHK("retrigger late", 1'b0, act)
      $display("selftest ended");
   endtask
   task automatic t_switch;
      cyc(1);
      above <= 1'b1;
      cyc(8);
      `CHK("on", 1'b0, oe_n)
      cyc(1);
      above <= 1'b0;
      cyc(8);
      `CHK("band", 1'b0, oe_n)
      cyc(1);
      below <= 1'b1;
      cyc(8);
      `CHK("off", 1'b1, oe_n)
      cyc(1);
      below <= 1'b0;
      above <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         cyc(8);
         flt <= 5'h01 << i;
         cyc(6);
         `CHK("fault oe", 1'b1, oe_n)
         `CHK("fault", 1'b1, flt_o)
         cyc(1);
         flt <= 5'h00;
      end
      $display("switching ended");
   endtask
   task automatic t_skip;
      cyc(1);
      srst_i <= 1'b1;
      host_low <= 1'b0;
      cyc(12);
      srst_i <= 1'b0;
      cyc(10);
      `CHK("skip done", 1'b1, done)
      `CHK("skip act", 1'b0, act)
      $display("skip ended");
   endtask
   task automatic t_freeze;
      cyc(8);
      `CHK("pre freeze", 1'b0, oe_n)
      cyc(1);
      ce <= 1'b0;
      above <= 1'b0;
      below <= 1'b1;
      cyc(8);
      `CHK("frozen", 1'b0, oe_n)
      cyc(1);
      ce <= 1'b1;
      cyc(8);
      `CHK("thawed", 1'b1, oe_n)
      `CHK("out data", 1'b0, dout)
      cyc(1);
      below <= 1'b0;
      above <= 1'b1;
      $display("freeze ended");
   endtask
   task automatic t_short;
      cyc(1);
      srst_i <= 1'b1;
      above <= 1'b0;
      host_low <= 1'b1;
      cyc(12);
      srst_i <= 1'b0;
      cyc(2);
      host_low <= 1'b0;
      cyc(10);
      `CHK("short act", 1'b0, act)
      `CHK("short done", 1'b1, done)
      `CHK("short oe", 1'b1, oe_n)
      $display("short low ended");
   endtask
   initial begin
      cyc(12);
      srst_i <= 1'b0;
      t_selftest;
      t_switch;
      t_freeze;
      t_skip;
      t_short;
      report_and_stop;
   end
endmodule // tb_magnetic_switch_selftest_safestate
`default_nettype wire
